// ==== include/voice_cmd_pkg.sv ====
`default_nettype none
package voice_cmd_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int FRAME_BITS    = 16;
  localparam int ADDR_BITS     = 11;
  localparam int CTRL_BITS     = 5;
  localparam int ROW_BITS      = 10;
  localparam int CNT_BITS      = 5;
  // control field positions inside the received frame
  localparam int CUE_ENABLE_POS   = 11;
  localparam int SKIP_ADDRESS_POS = 12;
  localparam int POWER_CTRL_POS   = 13;
  localparam int DIRECTION_POS    = 14;
  localparam int RUN_CTRL_POS     = 15;

  // ****************************************
  // storage array geometry
  // ****************************************
  localparam int ROW_COUNT     = 600;
  localparam int CELLS_PER_ROW = 1600;
  localparam logic [ROW_BITS-1:0] ROW_LAST = 10'h257;

  // ****************************************
  // control codes, bit 0 is cue_enable_bit
  // ****************************************
  localparam logic [CTRL_BITS-1:0] CMD_POWER_ON        = 5'h04;
  localparam logic [CTRL_BITS-1:0] CMD_LISTEN_AT_ADDR  = 5'h1c;
  localparam logic [CTRL_BITS-1:0] CMD_LISTEN_HERE     = 5'h1e;
  localparam logic [CTRL_BITS-1:0] CMD_CAPTURE_AT_ADDR = 5'h14;
  localparam logic [CTRL_BITS-1:0] CMD_CAPTURE_HERE    = 5'h16;
  localparam logic [CTRL_BITS-1:0] CMD_SKIP_AT_ADDR    = 5'h1d;
  localparam logic [CTRL_BITS-1:0] CMD_SKIP_HERE       = 5'h1f;
  // halt / read flags: direction bit is a don't care
  localparam logic [CTRL_BITS-1:0] CMD_HALT_MASK       = 5'h17;
  localparam logic [CTRL_BITS-1:0] CMD_HALT_VALUE      = 5'h06;
  // halt and sleep: cue and direction bits are don't care
  localparam logic [CTRL_BITS-1:0] CMD_HALT_SLEEP_MASK  = 5'h16;
  localparam logic [CTRL_BITS-1:0] CMD_HALT_SLEEP_VALUE = 5'h02;

  // ****************************************
  // status word shifted out
  // ****************************************
  localparam int STATUS_OVF_POS = 0;
  localparam int STATUS_EOM_POS = 1;
  localparam int STATUS_PTR_POS = 2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int WAKE_DELAY_US  = 25000;
  localparam int WAKE_CYCLES    = (WAKE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_BITS  = 20;

  // ****************************************
  // operation states
  // ****************************************
  typedef enum logic [2:0] {
    OP_OFF,
    OP_WAKING,
    OP_IDLE,
    OP_LISTEN,
    OP_CAPTURE,
    OP_SKIP
  } op_state_t;

endpackage
`default_nettype wire

// ==== rtl/voice_cmd_front.sv ====
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - falling select edge starts a new instruction frame
// - input sampled on rising clock, output changed on falling, lsb first
// - frame is 11 address bits then 5 control bits
// - operation ending on marker or overflow raises interrupt
// - pending interrupt clears when next frame begins
// - status shifts out while new command shifts in, same frame
// - run bit set starts operation, run bit clear ends it only in the halt and halt sleep codes
// - command acted on only after select returns high
// - power-on code wakes device, ready after wake delay
// - listen at addr starts playback at given row
// - listen here plays from current row until marker or overflow
// - capture at addr starts recording at given row
// - capture here records from current row until overflow or halt
// - skip at addr starts cueing at given row
// - skip here cues to next marker or overflow
// - halt code stops any running operation
// - halt sleep code stops and enters standby
// - read flags code returns overflow and marker flags
// - cueing accepted only when starting playback, not mid-playback
// - array is 600 rows of 1600 cells, rows within ten bits
// - control bits: cue, ignore address, power, direction, run
// - ignore address bit set discards row, clear uses it
// - interrupt is open-drain active low and latches
// - overflow at end of memory, marker flag only in playback or cueing
module voice_cmd_front #(
  parameter int WAKE_CYCLES = voice_cmd_pkg::WAKE_CYCLES
) (
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                reset_i,
  // serial pins from host
  input  wire logic                                sclk_i,
  input  wire logic                                mosi_i,
  input  wire logic                                ss_n_i,
  // serial output pin
  output logic                                     miso_o,
  output logic                                     miso_oe_o,
  // open-drain interrupt pin
  output logic                                     irq_n_o,
  output logic                                     irq_oe_o,
  // storage engine events, same clock
  input  wire logic                                end_of_memory_i,
  input  wire logic                                marker_found_i,
  input  wire logic [voice_cmd_pkg::ROW_BITS-1:0]  row_pointer_i,
  // storage engine control
  output logic                                     start_pulse_o,
  output logic                                     use_row_o,
  output logic [voice_cmd_pkg::ROW_BITS-1:0]       start_row_o,
  output logic                                     listen_o,
  output logic                                     capture_o,
  output logic                                     skip_o,
  output logic                                     powered_o,
  output logic                                     ready_o,
  // status
  output logic                                     overflow_flag_o,
  output logic                                     end_of_message_flag_o,
  output logic                                     frame_error_o
);

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    logic [2:0]                                 sclk_sync;
    logic [2:0]                                 ss_sync;
    logic [1:0]                                 mosi_sync;
    logic [voice_cmd_pkg::FRAME_BITS-1:0]       in_shift;
    logic [voice_cmd_pkg::FRAME_BITS-1:0]       out_shift;
    logic [voice_cmd_pkg::CNT_BITS-1:0]         bit_count;
    logic                                       miso;
    logic                                       miso_oe;
    voice_cmd_pkg::op_state_t                   op;
    logic [voice_cmd_pkg::WAKE_CNT_BITS-1:0]    wake_count;
    logic                                       overflow_flag;
    logic                                       end_of_message_flag;
    logic                                       irq_pending;
    logic                                       start_pulse;
    logic                                       use_row;
    logic [voice_cmd_pkg::ROW_BITS-1:0]         start_row;
    logic                                       frame_error;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ****************************************
  // helpers
  // ****************************************
  // rise and fall of a synchronised level, reads stages two and three only
  function automatic logic rose(input logic [2:0] s);
    rose = s[1] & ~s[2];
  endfunction

  function automatic logic fell(input logic [2:0] s);
    fell = ~s[1] & s[2];
  endfunction

  // control field match with don't-care mask
  function automatic logic ctrl_is(input logic [voice_cmd_pkg::CTRL_BITS-1:0] c,
                                   input logic [voice_cmd_pkg::CTRL_BITS-1:0] mask,
                                   input logic [voice_cmd_pkg::CTRL_BITS-1:0] value);
    ctrl_is = (c & mask) == value;
  endfunction

  localparam logic [voice_cmd_pkg::CTRL_BITS-1:0] FULL_MASK = 5'h1f;
  localparam logic [voice_cmd_pkg::WAKE_CNT_BITS-1:0] WAKE_LOAD =
    voice_cmd_pkg::WAKE_CNT_BITS'(WAKE_CYCLES - 1);
  localparam logic [voice_cmd_pkg::CNT_BITS-1:0] FRAME_LEN =
    voice_cmd_pkg::CNT_BITS'(voice_cmd_pkg::FRAME_BITS);
  localparam logic [voice_cmd_pkg::CNT_BITS-1:0] CNT_ONE = 5'h01;
  localparam logic [voice_cmd_pkg::WAKE_CNT_BITS-1:0] WAKE_ONE = 20'h00001;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    logic                                      sclk_rise;
    logic                                      sclk_fall;
    logic                                      frame_start;
    logic                                      frame_end;
    logic                                      selected;
    logic [voice_cmd_pkg::CTRL_BITS-1:0]       ctrl;
    logic [voice_cmd_pkg::ROW_BITS-1:0]        row;
    logic                                      skip_addr;
    logic                                      running;
    logic                                      ready;
    logic                                      ev_ovf;
    logic                                      ev_eom;
    logic                                      start_ok;
    voice_cmd_pkg::op_state_t                  start_op;
    logic                                      is_start;

    sclk_rise   = rose(state_reg.sclk_sync);
    sclk_fall   = fell(state_reg.sclk_sync);
    frame_start = fell(state_reg.ss_sync);
    frame_end   = rose(state_reg.ss_sync);
    selected    = ~state_reg.ss_sync[1];
    ctrl        = state_reg.in_shift[voice_cmd_pkg::RUN_CTRL_POS:voice_cmd_pkg::CUE_ENABLE_POS];
    row         = state_reg.in_shift[voice_cmd_pkg::ROW_BITS-1:0];
    skip_addr   = state_reg.in_shift[voice_cmd_pkg::SKIP_ADDRESS_POS];
    running     = (state_reg.op == voice_cmd_pkg::OP_LISTEN) ||
                  (state_reg.op == voice_cmd_pkg::OP_CAPTURE) ||
                  (state_reg.op == voice_cmd_pkg::OP_SKIP);
    ready       = running || (state_reg.op == voice_cmd_pkg::OP_IDLE);
    ev_ovf      = 1'b0;
    ev_eom      = 1'b0;
    start_ok    = 1'b0;
    start_op    = voice_cmd_pkg::OP_IDLE;
    is_start    = 1'b0;

    state_next             = state_reg;
    state_next.sclk_sync   = {state_reg.sclk_sync[1:0], sclk_i};
    state_next.ss_sync     = {state_reg.ss_sync[1:0], ss_n_i};
    state_next.mosi_sync   = {state_reg.mosi_sync[0], mosi_i};
    state_next.start_pulse = 1'b0;

    // frame start
    // select fall snapshots status and arms the shifters
    if (frame_start)
    begin
      state_next.bit_count = '0;
      state_next.in_shift  = '0;
      state_next.out_shift = '0;
      state_next.out_shift[voice_cmd_pkg::STATUS_OVF_POS] = state_reg.overflow_flag;
      state_next.out_shift[voice_cmd_pkg::STATUS_EOM_POS] = state_reg.end_of_message_flag;
      state_next.out_shift[voice_cmd_pkg::STATUS_PTR_POS +: voice_cmd_pkg::ROW_BITS] = row_pointer_i;
      state_next.miso      = state_reg.overflow_flag;
      state_next.miso_oe   = 1'b1;
      state_next.irq_pending         = 1'b0;
      state_next.overflow_flag       = 1'b0;
      state_next.end_of_message_flag = 1'b0;
    end
    else if (selected && sclk_rise)
    begin
      state_next.in_shift = {state_reg.mosi_sync[1], state_reg.in_shift[voice_cmd_pkg::FRAME_BITS-1:1]};
      if (state_reg.bit_count != '1)
        state_next.bit_count = state_reg.bit_count + CNT_ONE;
    end
    else if (selected && sclk_fall)
    begin
      state_next.out_shift = {1'b0, state_reg.out_shift[voice_cmd_pkg::FRAME_BITS-1:1]};
      state_next.miso      = state_reg.out_shift[1];
    end

    if (!selected && !frame_start)
    begin
      state_next.miso_oe = 1'b0;
      state_next.miso    = 1'b0;
    end

    // wake delay countdown
    // ready only after wake delay
    if (state_reg.op == voice_cmd_pkg::OP_WAKING)
    begin
      if (state_reg.wake_count == '0)
        state_next.op = voice_cmd_pkg::OP_IDLE;
      else
        state_next.wake_count = state_reg.wake_count - WAKE_ONE;
    end

    // storage engine terminations
    // overflow any run, marker only in playback or cueing
    if (running && end_of_memory_i)
      ev_ovf = 1'b1;
    else if ((state_reg.op == voice_cmd_pkg::OP_LISTEN || state_reg.op == voice_cmd_pkg::OP_SKIP) &&
             marker_found_i)
      ev_eom = 1'b1;
    if (ev_ovf || ev_eom)
      state_next.op = voice_cmd_pkg::OP_IDLE;

    if (frame_end)
    begin
      state_next.frame_error = state_reg.bit_count != FRAME_LEN;
      if (state_reg.bit_count == FRAME_LEN)
      begin
        if (ctrl_is(ctrl, voice_cmd_pkg::CMD_HALT_SLEEP_MASK, voice_cmd_pkg::CMD_HALT_SLEEP_VALUE))
          state_next.op = voice_cmd_pkg::OP_OFF;
        else if (ctrl_is(ctrl, voice_cmd_pkg::CMD_HALT_MASK, voice_cmd_pkg::CMD_HALT_VALUE))
        begin
          if (ready)
            state_next.op = voice_cmd_pkg::OP_IDLE;
        end
        else if (ctrl_is(ctrl, FULL_MASK, voice_cmd_pkg::CMD_POWER_ON))
        begin
          if (state_reg.op == voice_cmd_pkg::OP_OFF)
          begin
            state_next.op         = voice_cmd_pkg::OP_WAKING;
            state_next.wake_count = WAKE_LOAD;
          end
        end
        else if (ctrl_is(ctrl, FULL_MASK, voice_cmd_pkg::CMD_LISTEN_AT_ADDR) ||
                 ctrl_is(ctrl, FULL_MASK, voice_cmd_pkg::CMD_LISTEN_HERE))
        begin
          is_start = 1'b1;
          start_op = voice_cmd_pkg::OP_LISTEN;
        end
        else if (ctrl_is(ctrl, FULL_MASK, voice_cmd_pkg::CMD_CAPTURE_AT_ADDR) ||
                 ctrl_is(ctrl, FULL_MASK, voice_cmd_pkg::CMD_CAPTURE_HERE))
        begin
          is_start = 1'b1;
          start_op = voice_cmd_pkg::OP_CAPTURE;
        end
        else if (ctrl_is(ctrl, FULL_MASK, voice_cmd_pkg::CMD_SKIP_AT_ADDR) ||
                 ctrl_is(ctrl, FULL_MASK, voice_cmd_pkg::CMD_SKIP_HERE))
        begin
          is_start = 1'b1;
          start_op = voice_cmd_pkg::OP_SKIP;
        end

        start_ok = is_start && ready &&
                   !(start_op == voice_cmd_pkg::OP_SKIP && state_reg.op == voice_cmd_pkg::OP_LISTEN) &&
                   (skip_addr || row <= voice_cmd_pkg::ROW_LAST);
        if (start_ok && !(ev_ovf || ev_eom))
        begin
          state_next.op          = start_op;
          state_next.start_pulse = 1'b1;
          state_next.use_row     = ~skip_addr;
          state_next.start_row   = skip_addr ? state_reg.start_row : row;
        end
      end
    end

    // latched until next frame, set wins over clear
    if (ev_ovf)
    begin
      state_next.overflow_flag = 1'b1;
      state_next.irq_pending   = 1'b1;
    end
    if (ev_eom)
    begin
      state_next.end_of_message_flag = 1'b1;
      state_next.irq_pending         = 1'b1;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg           <= '0;
      state_reg.sclk_sync <= 3'h0;
      state_reg.ss_sync   <= 3'h7;   // deselected
      state_reg.op        <= voice_cmd_pkg::OP_OFF;
    end
    else
      state_reg <= state_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign miso_o                = state_reg.miso;
  assign miso_oe_o             = state_reg.miso_oe;
  assign irq_n_o               = ~state_reg.irq_pending;
  assign irq_oe_o              = state_reg.irq_pending;  // pulls low only
  assign start_pulse_o         = state_reg.start_pulse;
  assign use_row_o             = state_reg.use_row;
  assign start_row_o           = state_reg.start_row;
  assign listen_o              = state_reg.op == voice_cmd_pkg::OP_LISTEN;
  assign capture_o             = state_reg.op == voice_cmd_pkg::OP_CAPTURE;
  assign skip_o                = state_reg.op == voice_cmd_pkg::OP_SKIP;
  assign powered_o             = state_reg.op != voice_cmd_pkg::OP_OFF;
  assign ready_o               = (state_reg.op != voice_cmd_pkg::OP_OFF) &&
                                 (state_reg.op != voice_cmd_pkg::OP_WAKING);
  assign overflow_flag_o       = state_reg.overflow_flag;
  assign end_of_message_flag_o = state_reg.end_of_message_flag;
  assign frame_error_o         = state_reg.frame_error;

endmodule
`default_nettype wire

// ==== sim/host_spi_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// host side serial master, 800 ns clock
// ****************************************
module host_spi_model (
  // device output wire
  input  wire logic miso_i,
  // host driven pins
  output logic      sclk_o,
  output logic      mosi_o,
  output logic      ss_n_o
);
  // idle: clock still, select high
  initial
  begin
    sclk_o = 1'h0;
    mosi_o = 1'h0;
    ss_n_o = 1'h1;
  end

  // one frame of nbits, lsb first
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    // select fall opens frame of nbits
    ss_n_o = 1'h0;
    mosi_o = word[0];
    #800;
    for (int i = 0; i < nbits; i++)
    begin
      // change on fall, status read while sending
      sclk_o = 1'h1;
      #399;
      rx[i] = miso_i;
      #1;
      sclk_o = 1'h0;
      mosi_o = word[(i + 1) % 16];
      #400;
    end
    // select high between frames, data line inverted
    ss_n_o = 1'h1;
    mosi_o = ~mosi_o;
    #1000;
  endtask
endmodule
`default_nettype wire

// ==== sim/voice_cmd_front_checker.sv ====
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// port checker for the command front end
// ****************************************
module voice_cmd_front_checker #(
  parameter int WAKE_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // watched inputs
  input wire logic ss_n_i,
  input wire logic end_of_memory_i,
  input wire logic marker_found_i,
  // watched outputs
  input wire logic miso_oe_o,
  input wire logic irq_n_o,
  input wire logic irq_oe_o,
  input wire logic start_pulse_o,
  input wire logic listen_o,
  input wire logic capture_o,
  input wire logic skip_o,
  input wire logic powered_o,
  input wire logic ready_o,
  input wire logic overflow_flag_o,
  input wire logic end_of_message_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_oe_select: assert property ($fell(ss_n_i) |-> ##[2:5] miso_oe_o)
    else $error("serial output not driven after select fall");
  a_miso_idle: assert property (ss_n_i [*6] |-> !miso_oe_o)
    else $error("serial output driven while deselected");
  a_quiet_frame: assert property (!ss_n_i [*5] |-> !start_pulse_o)
    else $error("operation started inside a frame");
  a_pulse_single: assert property (start_pulse_o |=> !start_pulse_o)
    else $error("start pulse longer than one cycle");
  a_pulse_op: assert property (start_pulse_o |-> (listen_o || capture_o || skip_o) && ready_o)
    else $error("start without running operation or readiness");
  a_one_op: assert property ($onehot0({listen_o, capture_o, skip_o}))
    else $error("more than one operation running");
  a_ready_power: assert property (ready_o |-> powered_o)
    else $error("ready while in standby");
  a_irq_pin: assert property (irq_oe_o == !irq_n_o)
    else $error("interrupt enable and level disagree");
  a_irq_set: assert property ($rose(overflow_flag_o) || $rose(end_of_message_flag_o) |-> ##[0:1] !irq_n_o)
    else $error("flag set without interrupt");
  a_irq_clear: assert property ($fell(ss_n_i) |-> ##[1:6] irq_n_o)
    else $error("interrupt not cleared by new frame");
  a_eom_cause: assert property ($rose(end_of_message_flag_o) |-> $past(marker_found_i) || $past(marker_found_i, 2))
    else $error("marker flag without marker event");
  a_ovf_cause: assert property ($rose(overflow_flag_o) |-> $past(end_of_memory_i) || $past(end_of_memory_i, 2))
    else $error("overflow flag without end of memory");
endmodule

bind voice_cmd_front voice_cmd_front_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_checker (
  .clk_i(clk_i), .reset_i(reset_i), .ss_n_i(ss_n_i), .end_of_memory_i(end_of_memory_i),
  .marker_found_i(marker_found_i), .miso_oe_o(miso_oe_o), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o),
  .start_pulse_o(start_pulse_o), .listen_o(listen_o), .capture_o(capture_o), .skip_o(skip_o),
  .powered_o(powered_o), .ready_o(ready_o), .overflow_flag_o(overflow_flag_o),
  .end_of_message_flag_o(end_of_message_flag_o)
);
`default_nettype wire

// ==== sim/voice_recorder_spi_command_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// bench for the serial command front end
// ****************************************
module voice_recorder_spi_command_tb;
  localparam int WAKE = 20;
  logic                               clk_i = 1'h0;
  logic                               reset_i = 1'h1;
  logic                               end_of_memory_i = 1'h0;
  logic                               marker_found_i = 1'h0;
  logic [voice_cmd_pkg::ROW_BITS-1:0] row_pointer_i = 10'h000;
  wire logic                          sclk, mosi, ss_n, miso_w;
  logic miso_o, miso_oe_o, irq_n_o, irq_oe_o, start_pulse_o, use_row_o, listen_o, capture_o, skip_o;
  logic powered_o, ready_o, overflow_flag_o, end_of_message_flag_o, frame_error_o, miso_last = 1'h0;
  logic [9:0]                         start_row_o, row, last_row = 10'h000;
  logic [15:0]                        rx;
  logic [1:0]                         fl;
  int                                 miscompares = 0, cmp_count = 0, cycles = 0, pulses = 0, npulse;
  logic [4:0] codes [6] = '{voice_cmd_pkg::CMD_LISTEN_AT_ADDR, voice_cmd_pkg::CMD_CAPTURE_AT_ADDR,
    voice_cmd_pkg::CMD_SKIP_HERE, voice_cmd_pkg::CMD_LISTEN_HERE, voice_cmd_pkg::CMD_CAPTURE_HERE,
    voice_cmd_pkg::CMD_SKIP_AT_ADDR};
  int ev [6] = '{1, 1, 2, 0, 2, 1};

  voice_cmd_front #(.WAKE_CYCLES(WAKE)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .mosi_i(mosi), .ss_n_i(ss_n),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o),
    .end_of_memory_i(end_of_memory_i), .marker_found_i(marker_found_i), .row_pointer_i(row_pointer_i),
    .start_pulse_o(start_pulse_o), .use_row_o(use_row_o), .start_row_o(start_row_o), .listen_o(listen_o),
    .capture_o(capture_o), .skip_o(skip_o), .powered_o(powered_o), .ready_o(ready_o),
    .overflow_flag_o(overflow_flag_o), .end_of_message_flag_o(end_of_message_flag_o),
    .frame_error_o(frame_error_o));
  host_spi_model host (.miso_i(miso_w), .sclk_o(sclk), .mosi_o(mosi), .ss_n_o(ss_n));

  // released data line shows the inverse of its last level
  assign miso_w = miso_oe_o ? miso_o : ~miso_last;

  always #50 clk_i = ~clk_i;

  // pulse counter, line history and hang guard
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    pulses <= pulses + int'(start_pulse_o);
    if (miso_oe_o)
      miso_last <= miso_o;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one frame with a fresh row pointer, counts start pulses
  task automatic send(input logic [4:0] ctrl, input logic [10:0] addr, input int nbits = 16);
    int p0;
    @(posedge clk_i);
    #5;
    row_pointer_i = 10'($urandom_range(599));
    p0 = pulses;
    host.xfer({ctrl, addr}, nbits, rx);
    npulse = pulses - p0;
  endtask

  // one cycle storage event: 1 marker, 2 end of memory
  task automatic fire(input int kind);
    @(posedge clk_i);
    #5;
    marker_found_i = 1'(kind == 1);
    end_of_memory_i = 1'(kind == 2);
    @(posedge clk_i);
    #5;
    marker_found_i = 1'h0;
    end_of_memory_i = 1'h0;
    repeat (3) @(posedge clk_i);
    #5;
  endtask

  // running op as {skip, capture, listen}
  function automatic logic [2:0] op_of(input logic [4:0] c);
    if (c[0])
      return 3'h4;
    return c[3] ? 3'h1 : 3'h2;
  endfunction

  // flags as {marker, overflow} after an event
  function automatic logic [1:0] flags_of(input logic [4:0] c, input int kind);
    if (kind == 2)
      return 2'h1;
    return (kind == 1 && c[3]) ? 2'h2 : 2'h0;
  endfunction

  // main sequence
  initial
  begin
    void'($urandom(32'he504));
    repeat (10) @(posedge clk_i);
    #5 reset_i = 1'h0;
    check({irq_n_o, irq_oe_o, powered_o, ready_o}, 4'h8);
    send(voice_cmd_pkg::CMD_LISTEN_AT_ADDR, 11'h005);
    check({npulse[3:0], listen_o, powered_o}, 6'h00);
    send(voice_cmd_pkg::CMD_POWER_ON, 11'($urandom));
    check({powered_o, ready_o}, 2'h2);
    repeat (WAKE) @(posedge clk_i);
    #5;
    check({powered_o, ready_o}, 2'h3);
    foreach (codes[k])
    begin
      row = 10'($urandom_range(599));
      send(codes[k], {1'h0, row});
      check({npulse[3:0], skip_o, capture_o, listen_o}, {4'h1, op_of(codes[k])});
      check({use_row_o, start_row_o}, codes[k][1] ? {1'h0, last_row} : {1'h1, row});
      if (!codes[k][1])
        last_row = row;
      fire(ev[k]);
      fl = flags_of(codes[k], ev[k]);
      check({end_of_message_flag_o, overflow_flag_o, irq_n_o, irq_oe_o}, {fl, ~|fl, |fl});
      check({skip_o, capture_o, listen_o}, (fl != 2'h0) ? 3'h0 : op_of(codes[k]));
      send(voice_cmd_pkg::CMD_HALT_VALUE | (5'h08 & 5'($urandom)), 11'($urandom));
      check(rx, {4'h0, row_pointer_i, fl});
      check({irq_n_o, end_of_message_flag_o, overflow_flag_o, skip_o, capture_o, listen_o}, 6'h20);
    end
    // cue request in mid playback, then row past the array
    send(voice_cmd_pkg::CMD_LISTEN_HERE, 11'h000);
    send(voice_cmd_pkg::CMD_SKIP_HERE, 11'h000);
    check({npulse[3:0], skip_o, listen_o}, 6'h01);
    send(voice_cmd_pkg::CMD_LISTEN_AT_ADDR, 11'h258);
    check({npulse[3:0], listen_o, start_row_o}, {4'h0, 1'h1, last_row});
    send(voice_cmd_pkg::CMD_HALT_VALUE, 11'h000);
    send(voice_cmd_pkg::CMD_CAPTURE_AT_ADDR, 11'h257);
    check({npulse[3:0], capture_o, start_row_o}, {4'h1, 1'h1, 10'h257});
    // short frame refused, halt bits not acted on
    send(voice_cmd_pkg::CMD_HALT_VALUE, 11'h000, 15);
    check({frame_error_o, capture_o}, 2'h3);
    // standby with random don't care bits
    send(voice_cmd_pkg::CMD_HALT_SLEEP_VALUE | (5'h09 & 5'($urandom)), 11'($urandom));
    check({frame_error_o, capture_o, powered_o, ready_o}, 4'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
